// >>> verilog/rrc_defs.svh
// constants of the refresh-rate control block
//
// Functional notes
// - temperature control on: every refresh accepted, temperature-dependent share skipped internally; this block skips only in fixed 1x granularity.
// - interval stretched beyond normal only below 45 C, without host action.
// - extended range: host refreshes at 3.9 us, die halves that rate from 45 C up to below 85 C and quarters it below 45 C.
// - granularity field: 000 1x, 001 2x, 010 4x, 101 select 1x/2x, 110 select 1x/4x.
// - per-command settings: bank group bit 0 low means 1x, high means 2x or 4x.
// - after reset the die runs fixed 1x with the normal refresh cycle time.
// - least refresh cycle time 350 ns for 1x, 260 ns for 2x, 160 ns for 4x.
// - new interval and cycle time apply from the command that changes the rate.
`ifndef RRC_DEFS_SVH
`define RRC_DEFS_SVH

`define RRC_CLK_PERIOD_PS 5000
`define RRC_TRFC1_NS 350
`define RRC_TRFC2_NS 260
`define RRC_TRFC4_NS 160
`define RRC_TRFC1_CYC ((`RRC_TRFC1_NS * 1000 + `RRC_CLK_PERIOD_PS - 1) / `RRC_CLK_PERIOD_PS)
`define RRC_TRFC2_CYC ((`RRC_TRFC2_NS * 1000 + `RRC_CLK_PERIOD_PS - 1) / `RRC_CLK_PERIOD_PS)
`define RRC_TRFC4_CYC ((`RRC_TRFC4_NS * 1000 + `RRC_CLK_PERIOD_PS - 1) / `RRC_CLK_PERIOD_PS)

`define RRC_TEMP_COLD_C 45
`define RRC_TEMP_HOT_C 85

`define RRC_MR3_SEL_BA 2'h3
`define RRC_FGR_LSB 6
`define RRC_FGR_MSB 8

`define RRC_OFS_CTRL 8'h00
`define RRC_OFS_STATUS 8'h04
`define RRC_OFS_REF_COUNT 8'h08
`define RRC_OFS_SKIP_COUNT 8'h0c

`define RRC_CTRL_TCR_EN_BIT 0
`define RRC_CTRL_TCR_EXT_BIT 1
`define RRC_STAT_BUSY_BIT 4
`define RRC_STAT_VIOL_BIT 8
`define RRC_CTRL_RESET 2'h0

`endif

// >>> verilog/rrc_pkg.sv
// types of the refresh-rate control block
package rrc_pkg;

  typedef enum logic [2:0] {
    RRC_FGR_FIXED_1X = 3'b000,
    RRC_FGR_FIXED_2X = 3'b001,
    RRC_FGR_FIXED_4X = 3'b010,
    RRC_FGR_SEL_1X2X = 3'b101,
    RRC_FGR_SEL_1X4X = 3'b110
  } rrc_fgr_t;

  typedef enum logic [1:0] {
    RRC_RATE_1X = 2'b00,
    RRC_RATE_2X = 2'b01,
    RRC_RATE_4X = 2'b10
  } rrc_rate_t;

endpackage

// >>> verilog/rrc_cycle_timer.sv
// down-counter that holds a busy level for a loaded number of cycles
`timescale 1ns/1ps
module rrc_cycle_timer (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // load
  input wire logic load_in,
  input wire logic [6:0] load_val_in,
  // state
  output logic busy_out
);
  logic [6:0] count;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      count <= 7'h00;
    end else if (load_in) begin
      count <= load_val_in;
    end else if (count != 7'h00) begin
      count <= count - 7'h01;
    end
  end

  assign busy_out = (count != 7'h00);
endmodule

// >>> verilog/rrc_refresh_ctrl.sv
// refresh-rate control: granularity decode, temperature skipping, cycle-time guard, apb registers
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "rrc_defs.svh"
module rrc_refresh_ctrl
  import rrc_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // command bus, sampled on each rising clock edge
  input wire logic cmd_cs_n_in,
  input wire logic cmd_act_n_in,
  input wire logic cmd_ras_n_in,
  input wire logic cmd_cas_n_in,
  input wire logic cmd_we_n_in,
  input wire logic [1:0] cmd_bg_in,
  input wire logic [1:0] cmd_ba_in,
  input wire logic [13:0] cmd_addr_in,
  // temperature sensor, degrees celsius, signed
  input wire logic signed [7:0] case_temp_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // refresh engine
  output logic refresh_exec_out,
  output logic refresh_skip_out,
  output logic [1:0] refresh_rate_out,
  output logic refresh_busy_out,
  output logic [2:0] fine_granularity_refresh_out
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  wire cmd_sel = !cmd_cs_n_in;
  wire cmd_is_ref = cmd_sel && cmd_act_n_in && !cmd_ras_n_in && !cmd_cas_n_in && cmd_we_n_in;
  wire cmd_is_mrs = cmd_sel && cmd_act_n_in && !cmd_ras_n_in && !cmd_cas_n_in && !cmd_we_n_in;
  wire cmd_is_mr3 = cmd_is_mrs && !cmd_bg_in[1] && (cmd_ba_in == `RRC_MR3_SEL_BA);
  wire [2:0] mr3_code = cmd_addr_in[`RRC_FGR_MSB:`RRC_FGR_LSB];
  wire mr3_code_ok = (mr3_code == RRC_FGR_FIXED_1X) || (mr3_code == RRC_FGR_FIXED_2X) ||
                     (mr3_code == RRC_FGR_FIXED_4X) || (mr3_code == RRC_FGR_SEL_1X2X) ||
                     (mr3_code == RRC_FGR_SEL_1X4X);

  ////////////////////////////////////////////////////////////////////////////
  // fine granularity setting

  rrc_fgr_t fgr_mode;
  wire fgr_load = cmd_is_mr3 && mr3_code_ok;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      fgr_mode <= RRC_FGR_FIXED_1X;
    end else if (fgr_load) begin
      fgr_mode <= rrc_fgr_t'(mr3_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate of the refresh on the bus

  rrc_rate_t next_rate;

  always_comb begin
    unique case (fgr_mode)
      RRC_FGR_FIXED_1X: next_rate = RRC_RATE_1X;
      RRC_FGR_FIXED_2X: next_rate = RRC_RATE_2X;
      RRC_FGR_FIXED_4X: next_rate = RRC_RATE_4X;
      RRC_FGR_SEL_1X2X: next_rate = cmd_bg_in[0] ? RRC_RATE_2X : RRC_RATE_1X;
      RRC_FGR_SEL_1X4X: next_rate = cmd_bg_in[0] ? RRC_RATE_4X : RRC_RATE_1X;
      default: next_rate = RRC_RATE_1X;
    endcase
  end

  wire [6:0] trfc_cyc = (next_rate == RRC_RATE_4X) ? 7'(`RRC_TRFC4_CYC) :
                        (next_rate == RRC_RATE_2X) ? 7'(`RRC_TRFC2_CYC) :
                        7'(`RRC_TRFC1_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // refresh cycle time guard

  logic busy;

  rrc_cycle_timer u_trfc (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .load_in(cmd_is_ref),
    .load_val_in(trfc_cyc),
    .busy_out(busy)
  );

  // anything but a deselect while busy breaks the cycle-time contract
  wire viol_event = busy && cmd_sel;

  ////////////////////////////////////////////////////////////////////////////
  // temperature-controlled skipping

  logic tcr_en;
  logic tcr_ext;
  logic [1:0] gear_phase;

  wire temp_cold = case_temp_in < 8'sd`RRC_TEMP_COLD_C;
  wire temp_hot = case_temp_in >= 8'sd`RRC_TEMP_HOT_C;
  wire tcr_active = tcr_en && (fgr_mode == RRC_FGR_FIXED_1X);
  // gear mask: 0 keeps all, 1 keeps one of two, 3 keeps one of four
  wire [1:0] gear_mask = !tcr_active ? 2'h0 :
                         temp_hot ? 2'h0 :
                         (tcr_ext && temp_cold) ? 2'h3 :
                         (tcr_ext || temp_cold) ? 2'h1 : 2'h0;
  wire ref_keep = ((gear_phase & gear_mask) == 2'h0);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      gear_phase <= 2'h0;
    end else if (!tcr_active) begin
      gear_phase <= 2'h0;
    end else if (cmd_is_ref) begin
      gear_phase <= gear_phase + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh engine outputs and counters

  logic [15:0] ref_count;
  logic [15:0] skip_count;
  logic viol_flag;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      refresh_exec_out <= 1'b0;
      refresh_skip_out <= 1'b0;
      refresh_rate_out <= RRC_RATE_1X;
    end else begin
      refresh_exec_out <= cmd_is_ref && ref_keep;
      refresh_skip_out <= cmd_is_ref && !ref_keep;
      if (cmd_is_ref) begin
        refresh_rate_out <= next_rate;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ref_count <= 16'h0000;
      skip_count <= 16'h0000;
    end else if (cmd_is_ref) begin
      if (ref_keep) begin
        ref_count <= ref_count + 16'h0001;
      end else begin
        skip_count <= skip_count + 16'h0001;
      end
    end
  end

  assign refresh_busy_out = busy;
  assign fine_granularity_refresh_out = fgr_mode;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  wire apb_setup = psel_in && !penable_in;
  wire apb_wr = psel_in && penable_in && pwrite_in;
  wire hit_ctrl = (paddr_in == `RRC_OFS_CTRL);
  wire hit_stat = (paddr_in == `RRC_OFS_STATUS);
  wire hit_refc = (paddr_in == `RRC_OFS_REF_COUNT);
  wire hit_skip = (paddr_in == `RRC_OFS_SKIP_COUNT);
  wire hit_any = hit_ctrl || hit_stat || hit_refc || hit_skip;
  wire viol_clear = apb_wr && hit_stat && pwdata_in[`RRC_STAT_VIOL_BIT];

  wire [31:0] stat_word = {23'h000000, viol_flag, 1'b0, refresh_rate_out, busy, 1'b0, fgr_mode};
  wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, tcr_ext, tcr_en} :
                       hit_stat ? stat_word :
                       hit_refc ? {16'h0000, ref_count} :
                       hit_skip ? {16'h0000, skip_count} : 32'h00000000;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      {tcr_ext, tcr_en} <= `RRC_CTRL_RESET;
    end else if (apb_wr && hit_ctrl) begin
      tcr_en <= pwdata_in[`RRC_CTRL_TCR_EN_BIT];
      tcr_ext <= pwdata_in[`RRC_CTRL_TCR_EXT_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      viol_flag <= 1'b0;
    end else if (viol_event) begin
      viol_flag <= 1'b1;
    end else if (viol_clear) begin
      viol_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (apb_setup) begin
      prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
      pslverr_out <= !hit_any;
    end
  end

  assign pready_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_ref_1x_taken;
    cmd_is_ref && (next_rate == RRC_RATE_1X);
  endsequence

  sequence s_busy_for_1x;
    busy [*8] ##1 busy [*8];
  endsequence

  // busy stays for at least 16 cycles after a 1x refresh and ends on time
  logic [6:0] ast_busy_len;
  always_ff @(posedge mclk_in) begin
    if (reset_in || cmd_is_ref) begin
      ast_busy_len <= 7'h00;
    end else if (busy) begin
      ast_busy_len <= ast_busy_len + 7'h01;
    end
  end

  AST_TRFC1_BUSY: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_ref_1x_taken |=> s_busy_for_1x)
    else $error("busy dropped early after a 1x refresh");

  AST_TRFC_LEN: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(busy) |-> (ast_busy_len == 7'(`RRC_TRFC1_CYC)) || (ast_busy_len == 7'(`RRC_TRFC2_CYC)) ||
      (ast_busy_len == 7'(`RRC_TRFC4_CYC)))
    else $error("busy length matches no refresh cycle time");

  AST_TRFC_BY_RATE: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(busy) |-> (ast_busy_len == ((refresh_rate_out == RRC_RATE_4X) ? 7'(`RRC_TRFC4_CYC) :
      (refresh_rate_out == RRC_RATE_2X) ? 7'(`RRC_TRFC2_CYC) : 7'(`RRC_TRFC1_CYC))))
    else $error("busy length does not fit the rate of the last refresh");

  AST_RESET_1X: assert property (@(posedge mclk_in)
    $fell(reset_in) |-> (fine_granularity_refresh_out == RRC_FGR_FIXED_1X))
    else $error("granularity not fixed 1x after reset");

  AST_RESERVED_IGNORED: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_mr3 && !mr3_code_ok) |=> $stable(fine_granularity_refresh_out))
    else $error("reserved granularity code changed the setting");

  AST_MR3_LOAD: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_mr3 && mr3_code_ok) |=> (fine_granularity_refresh_out == $past(mr3_code)))
    else $error("granularity code not taken");

  AST_SEL_RATE: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && fgr_mode == RRC_FGR_SEL_1X4X) |=>
      (refresh_rate_out == ($past(cmd_bg_in[0]) ? RRC_RATE_4X : RRC_RATE_1X)))
    else $error("per-command rate not taken from bank group bit 0");

  AST_SEL_RATE_2X: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && fgr_mode == RRC_FGR_SEL_1X2X) |=>
      (refresh_rate_out == ($past(cmd_bg_in[0]) ? RRC_RATE_2X : RRC_RATE_1X)))
    else $error("per-command double rate not taken from bank group bit 0");

  AST_FIXED_4X: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && fgr_mode == RRC_FGR_FIXED_4X) |=> (refresh_rate_out == RRC_RATE_4X))
    else $error("fixed 4x setting gave another rate");

  AST_NO_SKIP_OFF: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && !tcr_active) |=> refresh_exec_out && !refresh_skip_out)
    else $error("refresh skipped without temperature control");

  AST_NO_SKIP_HOT: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && !temp_cold && !tcr_ext) |=> !refresh_skip_out)
    else $error("normal range skipped at or above 45 C");

  AST_EXT_HALF: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && tcr_active && tcr_ext && !temp_cold && !temp_hot) |=>
      (refresh_exec_out == !$past(gear_phase[0])) && (refresh_exec_out ^ refresh_skip_out))
    else $error("extended range refresh not kept one of two");

  AST_EXT_COLD_QUARTER: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && tcr_active && tcr_ext && temp_cold) |=>
      (refresh_exec_out == ($past(gear_phase) == 2'h0)) && (refresh_exec_out ^ refresh_skip_out))
    else $error("cold extended range refresh not kept one of four");

  AST_NORMAL_COLD_HALF: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && tcr_active && !tcr_ext && temp_cold) |=>
      (refresh_exec_out == !$past(gear_phase[0])) && (refresh_exec_out ^ refresh_skip_out))
    else $error("cold normal range refresh not kept one of two");

  AST_HOT_KEEPS: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cmd_is_ref && temp_hot) |=> refresh_exec_out && !refresh_skip_out)
    else $error("refresh skipped at or above 85 C");

  AST_VIOL_SET_WINS: assert property (@(posedge mclk_in) disable iff (reset_in)
    viol_event |=> viol_flag)
    else $error("cycle-time breach not recorded");

  AST_VIOL_CLEAR: assert property (@(posedge mclk_in) disable iff (reset_in)
    (viol_clear && !viol_event) |=> !viol_flag)
    else $error("cycle-time breach flag not cleared");

endmodule

// >>> dv/rrc_host_model.sv
// behavioural memory controller issuing refresh and mr3 writes on request
`timescale 1ns/1ps
module rrc_host_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // request from bench
  input wire logic req_in,
  input wire logic mrs_in,
  input wire logic bg0_in,
  input wire logic [2:0] code_in,
  output logic ready_out,
  // command bus
  output logic cs_n_out,
  output logic act_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [1:0] bg_out,
  output logic [1:0] ba_out,
  output logic [13:0] addr_out
);
  logic [2:0] code;
  logic [7:0] wait_cnt;
  logic cs = 1'h1;
  logic [21:0] pins = '0;
  logic dbl;
  logic quad;

  assign dbl = (code == 3'h1) || (code == 3'h5 && bg0_in);
  assign quad = (code == 3'h2) || (code == 3'h6 && bg0_in);
  assign ready_out = (wait_cnt == 8'h00);
  assign cs_n_out = cs;
  assign {act_n_out, ras_n_out, cas_n_out, we_n_out, bg_out, ba_out, addr_out} = pins;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_in) begin
    if (reset_in) begin
      code <= 3'h0;
      wait_cnt <= 8'h00;
      cs <= 1'h1;
    end else if (req_in) begin
      cs <= 1'h0;
      pins <= {3'h4, ~mrs_in, 1'h0, bg0_in, mrs_in ? 2'h3 : 2'h0, 5'h00, code_in, 6'h00};
      if (mrs_in) begin
        code <= code_in;
        wait_cnt <= 8'h04;
      end else begin
        wait_cnt <= dbl ? 8'h36 : (quad ? 8'h22 : 8'h48);
      end
    end else begin
      cs <= 1'h1;
      // deselected pins keep moving so no stale value reads as valid
      pins <= ~pins;
      if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench of the refresh-rate control block
`timescale 1ns/1ps
module tb
  import rrc_pkg::*;
;
  logic mclk_in = 1'h0;
  logic reset_in = 1'h1;
  logic req = 1'h0, mrs = 1'h0, bg0 = 1'h0;
  logic [2:0] code = 3'h0;
  logic signed [7:0] temp = 8'h3c;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, exec, skip, busy, rdy, cs_n, act_n, ras_n, cas_n, we_n;
  logic [1:0] rate, bg, ba;
  logic [2:0] fgr;
  logic [13:0] addr;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  always #2.5 mclk_in = ~mclk_in;

  rrc_host_model host (.mclk_in(mclk_in), .reset_in(reset_in), .req_in(req), .mrs_in(mrs), .bg0_in(bg0),
    .code_in(code), .ready_out(rdy), .cs_n_out(cs_n), .act_n_out(act_n), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .we_n_out(we_n), .bg_out(bg), .ba_out(ba), .addr_out(addr));

  rrc_refresh_ctrl uut (.mclk_in(mclk_in), .reset_in(reset_in), .cmd_cs_n_in(cs_n), .cmd_act_n_in(act_n),
    .cmd_ras_n_in(ras_n), .cmd_cas_n_in(cas_n), .cmd_we_n_in(we_n), .cmd_bg_in(bg), .cmd_ba_in(ba),
    .cmd_addr_in(addr), .case_temp_in(temp), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .refresh_exec_out(exec), .refresh_skip_out(skip), .refresh_rate_out(rate), .refresh_busy_out(busy),
    .fine_granularity_refresh_out(fgr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'h1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // wt low sends regardless of the controller's own spacing
  task automatic cmd(input logic m, input logic b, input logic [2:0] c, input logic wt);
    @(posedge mclk_in);
    while (wt && rdy !== 1'h1) begin
      @(posedge mclk_in);
    end
    req <= 1'h1;
    mrs <= m;
    bg0 <= b;
    code <= c;
    @(posedge mclk_in);
    req <= 1'h0;
  endtask

  task automatic ref_chk(input logic b, input logic k, input logic [1:0] r, input int t);
    int n;
    cmd(1'h0, b, 3'h0, 1'h1);
    @(posedge mclk_in);
    #1;
    chk("exec", k, exec);
    chk("skip", !k, skip);
    if (k) begin
      chk("rate", r, rate);
      n = 0;
      while (busy === 1'h1 && n < 100) begin
        @(posedge mclk_in);
        #1;
        n++;
      end
      chk("busy cycles", t, n);
    end
  endtask

  task automatic mr3(input logic [2:0] c, input logic [2:0] e);
    cmd(1'h1, 1'h0, c, 1'h1);
    @(posedge mclk_in);
    #1;
    chk("granularity", e, fgr);
  endtask

  task automatic temp_controlled_refresh(input logic [1:0] ctl, input logic signed [7:0] tc, input logic [3:0] pat);
    apb(1'h1, 8'h00, 32'h0);
    temp <= tc;
    apb(1'h1, 8'h00, {30'h0, ctl});
    for (int i = 0; i < 4; i++) ref_chk(1'h0, pat[i], RRC_RATE_1X, 70);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("granularity", 3'h0, fgr);
    chk("busy", 1'h0, busy);
    apb(1'h0, 8'h04, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped err", 1'h1, err);
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_rates();
    ref_chk(1'h0, 1'h1, RRC_RATE_1X, 70);
    mr3(3'h1, 3'h1);
    ref_chk(1'h0, 1'h1, RRC_RATE_2X, 52);
    ref_chk(1'h0, 1'h1, RRC_RATE_2X, 52);
    mr3(3'h2, 3'h2);
    for (int i = 0; i < 4; i++) ref_chk(1'h0, 1'h1, RRC_RATE_4X, 32);
    apb(1'h0, 8'h04, 32'h0);
    chk("status", 32'h42, rd);
    mr3(3'h5, 3'h5);
    ref_chk(1'h0, 1'h1, RRC_RATE_1X, 70);
    for (int i = 0; i < 2; i++) ref_chk(1'h1, 1'h1, RRC_RATE_2X, 52);
    mr3(3'h6, 3'h6);
    ref_chk(1'h0, 1'h1, RRC_RATE_1X, 70);
    for (int i = 0; i < 3; i++) ref_chk(1'h1, 1'h1, RRC_RATE_4X, 32);
    mr3(3'h3, 3'h6);
    mr3(3'h4, 3'h6);
    mr3(3'h7, 3'h6);
    ref_chk(1'h1, 1'h1, RRC_RATE_4X, 32);
    mr3(3'h0, 3'h0);
  endtask

  task automatic t_tcr();
    temp_controlled_refresh(2'h1, 8'h1e, 4'h5);
    temp_controlled_refresh(2'h1, 8'h3c, 4'hf);
    temp_controlled_refresh(2'h3, 8'h3c, 4'h5);
    temp_controlled_refresh(2'h3, 8'h1e, 4'h1);
    temp_controlled_refresh(2'h3, 8'h5a, 4'hf);
    apb(1'h0, 8'h00, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'h0, 8'h0c, 32'h0);
    chk("skip count", 32'h7, rd);
    apb(1'h1, 8'h00, 32'h0);
  endtask

  task automatic t_breach();
    cmd(1'h0, 1'h0, 3'h0, 1'h1);
    cmd(1'h0, 1'h0, 3'h0, 1'h0);
    apb(1'h0, 8'h04, 32'h0);
    chk("breach flag", 1'h1, rd[8]);
    apb(1'h1, 8'h04, 32'h100);
    apb(1'h0, 8'h04, 32'h0);
    chk("status", 32'h10, rd);
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'h0;
    #1;
    t_reset();
    t_rates();
    t_tcr();
    t_breach();
    final_report();
  end
endmodule
